// *** sim/bm_read_mailbox_properties.sv ***
// Concurrent checks on the read channel and register ports
module bm_read_mailbox_properties (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Watched inputs
  input wire logic i_pci_sel,
  input wire logic i_pci_wr,
  input wire logic [7:0] i_pci_addr,
  input wire logic i_addon_owns_bm,
  input wire logic i_addon_sel,
  input wire logic i_addon_wr,
  input wire logic i_done_irq_en,
  // Watched outputs
  input wire logic [31:0] o_pci_rdata,
  input wire logic o_pci_rvalid,
  input wire logic o_addon_rvalid,
  input wire logic o_read_busy,
  input wire logic o_read_done,
  input wire logic o_mst_req,
  input wire logic o_mst_addr_phase,
  input wire logic [31:0] o_mst_addr,
  input wire logic [3:0] o_mst_be
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_pci_rd;
    i_pci_sel && !i_pci_wr;
  endsequence
  sequence s_hidden;
    i_addon_owns_bm && i_pci_addr == bm_read_pkg::OFS_BM_READ_ADDRESS;
  endsequence
  a_addr_low_zero: assert property (o_mst_addr[1:0] == 2'h0)
    else $error("master address low bits not zero");
  a_pci_read_answer: assert property (s_pci_rd |=> o_pci_rvalid)
    else $error("target read not answered");
  a_owner_hides: assert property (s_pci_rd ##0 s_hidden |=> o_pci_rdata == 32'h0000_0000)
    else $error("address visible to non-owner");
  a_addon_answer: assert property (i_addon_sel && !i_addon_wr |=> o_addon_rvalid)
    else $error("add-on read not answered");
  a_addr_step: assert property (o_read_busy && $past(o_read_busy) && o_mst_addr != $past(o_mst_addr)
    |-> o_mst_addr == $past(o_mst_addr) + 32'h0000_0004) else $error("address step not four");
  a_req_in_busy: assert property (o_mst_req |-> o_read_busy)
    else $error("request outside transfer");
  a_phase_with_req: assert property (o_mst_addr_phase |-> o_mst_req)
    else $error("address phase without request");
  a_be_lanes: assert property (o_mst_req |-> o_mst_be inside {4'hf, 4'h7, 4'h3, 4'h1})
    else $error("byte enables not a low run");
  a_done_cause: assert property ($rose(o_read_done) |-> $past(o_read_busy) && $past(i_done_irq_en))
    else $error("done set without transfer or enable");
endmodule
bind bm_read_mailbox bm_read_mailbox_properties chk (.i_sys_clk, .i_rstn, .i_pci_sel, .i_pci_wr, .i_pci_addr,
  .i_addon_owns_bm, .i_addon_sel, .i_addon_wr, .i_done_irq_en, .o_pci_rdata, .o_pci_rvalid, .o_addon_rvalid,
  .o_read_busy, .o_read_done, .o_mst_req, .o_mst_addr_phase, .o_mst_addr, .o_mst_be);

// *** sim/pci_read_master_mailbox_status_bench.sv ***
// Self-checking bench for the read channel and mailbox status block
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module pci_read_master_mailbox_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk, i_rstn, i_pci_sel, i_pci_wr, i_addon_sel, i_addon_owns_bm, slow;
  logic i_read_enable, i_done_irq_en, i_done_clr, i_mst_ack, i_stream_ready;
  logic o_pci_rvalid, o_addon_rvalid, o_read_busy, o_read_done, o_mst_req, o_stream_valid, o_mst_addr_phase;
  logic [7:0] i_pci_addr;
  logic [3:0] o_mst_be, last_be;
  logic [15:0] i_in_mb_wr_be, i_in_mb_rd_be, i_out_mb_wr_be, i_out_mb_rd_be, in_m, out_m;
  logic [31:0] i_pci_wdata, o_pci_rdata, o_addon_rdata, i_mst_data, o_mst_addr, o_stream_data, rd, ph_addr;
  logic [31:0] sq[$];
  int n_mismatch, total_checks, cyc, seed, nph;
  bm_read_mailbox dut (.i_sys_clk, .i_rstn, .i_pci_sel, .i_pci_wr, .i_pci_addr, .i_pci_be(4'hf), .i_pci_wdata,
    .o_pci_rdata, .o_pci_rvalid, .i_addon_owns_bm, .i_addon_sel, .i_addon_wr(i_pci_wr), .i_addon_addr(i_pci_addr),
    .i_addon_be(4'hf), .i_addon_wdata(i_pci_wdata), .o_addon_rdata, .o_addon_rvalid, .i_read_enable,
    .i_done_irq_en, .i_done_clr, .o_read_busy, .o_read_done, .o_mst_req, .o_mst_addr_phase, .o_mst_addr,
    .o_mst_be, .i_mst_ack, .i_mst_data, .i_in_mb_wr_be, .i_in_mb_rd_be, .i_out_mb_wr_be, .i_out_mb_rd_be,
    .o_stream_data, .o_stream_valid, .i_stream_ready);
  target_mem_model mem (.i_sys_clk, .i_rstn, .i_slow(slow), .i_req(o_mst_req), .i_addr(o_mst_addr),
    .o_ack(i_mst_ack), .o_data(i_mst_data));
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) if (o_stream_valid && i_stream_ready) sq.push_back(o_stream_data);
  // Byte enables of the last data phase and address of the first address phase
  always @(posedge i_sys_clk) begin
    if (o_mst_req && i_mst_ack) last_be = o_mst_be;
    if (o_mst_addr_phase) begin
      if (nph == 0) ph_addr = o_mst_addr;
      nph++;
    end
  end
  always @(negedge i_sys_clk) i_stream_ready = ($random(seed) & 3) != 0;
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic acc(input logic a, input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(negedge i_sys_clk);
    i_pci_sel = !a;
    i_addon_sel = a;
    i_pci_wr = w;
    i_pci_addr = ad;
    i_pci_wdata = d;
    @(negedge i_sys_clk);
    i_pci_sel = 1'b0;
    i_addon_sel = 1'b0;
    rd = a ? o_addon_rdata : o_pci_rdata;
    if (!w) `CHK("rvalid", 1'b1, a ? o_addon_rvalid : o_pci_rvalid)
  endtask
  task automatic xfer(input logic [31:0] cnt, input logic s, input logic en);
    logic [31:0] a0;
    int nw;
    a0 = 32'h0000_0200 + ($random(seed) & 32'h0000_0ff0);
    nw = int'((cnt + 32'h3) >> 2);
    acc(0, 1, 8'h2c, a0);
    acc(0, 1, 8'h30, cnt);
    slow = s;
    i_done_irq_en = en;
    sq.delete();
    nph = 0;
    i_read_enable = 1'b1;
    acc(0, 0, 8'h2c, 0);
    `CHK("mid addr", 1'b1, rd >= a0 && rd <= a0 + cnt && rd[1:0] == 2'h0)
    acc(0, 1, 8'h30, 0);
    for (int k = 0; k < 600 && (o_read_busy || sq.size() < nw); k++) @(negedge i_sys_clk);
    i_read_enable = 1'b0;
    acc(0, 0, 8'h2c, 0);
    `CHK("end addr", a0 + (cnt & 32'hffff_fffc), rd)
    acc(0, 0, 8'h30, 0);
    `CHK("end count", 32'h0, rd)
    `CHK("done", en, o_read_done)
    `CHK("words", nw, sq.size())
    `CHK("last be", cnt[1:0] == 2'h0 ? 4'hf : ~(4'hf << cnt[1:0]), last_be)
    `CHK("phase addr", a0, ph_addr)
    foreach (sq[k]) `CHK("stream", {a0[15:0] + 16'(4 * k), ~(a0[15:0] + 16'(4 * k))}, sq[k])
    i_done_clr = 1'b1;
    @(negedge i_sys_clk);
    i_done_clr = 1'b0;
    @(negedge i_sys_clk);
    `CHK("done clear", 1'b0, o_read_done)
    $display("test transfer %0d done", cnt);
  endtask
  initial begin
    seed = 32'h29eba26c;
    {i_rstn, i_pci_sel, i_pci_wr, i_addon_sel, i_addon_owns_bm, slow, i_read_enable} = '0;
    {i_done_irq_en, i_done_clr, i_pci_addr, i_pci_wdata, in_m, out_m} = '0;
    {i_in_mb_wr_be, i_in_mb_rd_be, i_out_mb_wr_be, i_out_mb_rd_be} = '0;
    repeat (3) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    for (int k = 0; k < 4; k++) begin
      acc(0, 0, 8'h2c + 8'(4 * k), 0);
      `CHK("reset or unmapped", 32'h0, rd)
    end
    acc(0, 1, 8'h34, 32'hffff_ffff);
    $display("test reset values done");
    for (int k = 0; k < 10; k++) begin
      @(negedge i_sys_clk);
      {i_in_mb_wr_be, i_in_mb_rd_be} = $random(seed);
      {i_out_mb_wr_be, i_out_mb_rd_be} = $random(seed);
      in_m = (in_m & ~i_in_mb_rd_be) | i_in_mb_wr_be;
      out_m = (out_m & ~i_out_mb_rd_be) | i_out_mb_wr_be;
      @(negedge i_sys_clk);
      {i_in_mb_wr_be, i_in_mb_rd_be, i_out_mb_wr_be, i_out_mb_rd_be} = '0;
      acc(0, 0, 8'h34, 0);
      `CHK("fullness", {in_m, out_m}, rd)
    end
    $display("test mailbox done");
    xfer(32'h14, 0, 1);
    xfer(32'h0d, 1, 1);
    xfer(32'h03, 0, 0);
    xfer(($random(seed) & 32'h3f) + 32'h1, 1, 1);
    i_addon_owns_bm = 1'b1;
    acc(1, 1, 8'h2c, 32'h0000_0307);
    acc(0, 1, 8'h2c, 32'h0000_0500);
    acc(1, 0, 8'h2c, 0);
    `CHK("addon addr", 32'h0000_0304, rd)
    acc(0, 0, 8'h2c, 0);
    `CHK("pci hidden", 32'h0, rd)
    i_addon_owns_bm = 1'b0;
    $display("test ownership done");
    tally_and_finish();
  end
endmodule

// *** sim/target_mem_model.sv ***
// Target memory answering the read channel's data phases
module target_mem_model (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  output logic o_ack,
  output logic [31:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_reg;
  logic [31:0] last_reg;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) cnt_reg <= 2'h0;
    else cnt_reg <= cnt_reg + 2'h1;
  end
  always_ff @(posedge i_sys_clk) last_reg <= o_data;
  // Every phase of the burst is served, no early disconnect
  assign o_ack = i_req && (!i_slow || cnt_reg == 2'h0);
  // Data carries its own address; off a phase the bus shows junk
  assign o_data = o_ack ? {i_addr[15:0], ~i_addr[15:0]} : ~last_reg;
endmodule

// *** verilog/bm_read_mailbox.sv ***
// Bus-master read channel registers, read engine and mailbox fullness status
//
// Functional notes
// R1 - Read address is 30-bit counter, bits 1:0 zero
// R2 - Software programs nonzero length, DWORD-aligned start
// R3 - Address advances, always points to next unread; a final partial DWORD does not advance it
// R4 - Address readable as target during transfer
// R5 - Address phase drives low two bits zero
// R6 - Bit A1 always zero while bus master
// R7 - Target should not disconnect after first phase
// R8 - Count holds remaining bytes, decrements per read
// R9 - Count zero stops transfer, optional completion interrupt
// R10 - Odd length ends with partial byte-enabled cycle
// R11 - Address and count reachable from add-on side
// R12 - Incoming status bits 31:16, outgoing 15:0
// R13 - Bit is one while written, not read
// R14 - Incoming is add-on to PCI, outgoing reverse
// R15 - Incoming set by add-on write, cleared PCI read
// R16 - Outgoing set by PCI write, cleared add-on read
// R17 - Outgoing bits: four per mailbox, ascending order
// R18 - Incoming bits same ordering offset by sixteen
// R19 - Address plus four per DWORD, count minus bytes
// R20 - Read-complete status set at zero when enabled
module bm_read_mailbox (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // PCI target register port
  input wire logic i_pci_sel,
  input wire logic i_pci_wr,
  input wire logic [7:0] i_pci_addr,
  input wire logic [3:0] i_pci_be,
  input wire logic [31:0] i_pci_wdata,
  output logic [31:0] o_pci_rdata,
  output logic o_pci_rvalid,
  // Add-on register port for the read channel registers
  input wire logic i_addon_owns_bm,
  input wire logic i_addon_sel,
  input wire logic i_addon_wr,
  input wire logic [7:0] i_addon_addr,
  input wire logic [3:0] i_addon_be,
  input wire logic [31:0] i_addon_wdata,
  output logic [31:0] o_addon_rdata,
  output logic o_addon_rvalid,
  // Read channel control and completion status
  input wire logic i_read_enable,
  input wire logic i_done_irq_en,
  input wire logic i_done_clr,
  output logic o_read_busy,
  output logic o_read_done,
  // Bus-master read request and data phases
  output logic o_mst_req,
  output logic o_mst_addr_phase,
  output logic [31:0] o_mst_addr,
  output logic [3:0] o_mst_be,
  input wire logic i_mst_ack,
  input wire logic [31:0] i_mst_data,
  // Mailbox byte events
  input wire logic [15:0] i_in_mb_wr_be,
  input wire logic [15:0] i_in_mb_rd_be,
  input wire logic [15:0] i_out_mb_wr_be,
  input wire logic [15:0] i_out_mb_rd_be,
  // Read data stream toward the add-on side
  output logic [31:0] o_stream_data,
  output logic o_stream_valid,
  input wire logic i_stream_ready
);
  bm_read_pkg::rd_state_t state_reg, state_next;
  logic [29:0] addr_reg, addr_next;
  logic [31:0] count_reg, count_next;
  logic [15:0] in_full_reg;
  logic [15:0] out_full_reg;
  logic done_reg, done_next;
  logic busy_reg, busy_next;
  logic req_reg, req_next;
  logic addr_phase_reg, addr_phase_next;
  logic [3:0] be_reg, be_next;
  logic [31:0] pci_rdata_reg, pci_rdata_next;
  logic pci_rvalid_reg, pci_rvalid_next;
  logic [31:0] addon_rdata_reg, addon_rdata_next;
  logic addon_rvalid_reg, addon_rvalid_next;
  logic bm_wr, beat, fifo_in_ready;
  logic [7:0] bm_addr;
  logic [3:0] bm_be;
  logic [31:0] bm_wdata, addr_word, full_word, bm_rd_word;
  logic [31:0] addr_merged;
  logic wr_addr_hit, wr_count_hit;
  logic [4:0] fifo_level;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Byte enables for the next data phase given the bytes left
  function automatic logic [3:0] lane_mask(input logic [31:0] left);
    logic [3:0] m;
    if (left >= bm_read_pkg::DWORD_BYTES) begin
      m = bm_read_pkg::BE_ALL;
    end else begin
      case (left[1:0])
        2'h1: m = 4'h1;
        2'h2: m = 4'h3;
        2'h3: m = 4'h7;
        default: m = bm_read_pkg::BE_NONE;
      endcase
    end
    return m;
  endfunction

  data_fifo #(
    .WIDTH(bm_read_pkg::FIFO_WIDTH),
    .DEPTH(bm_read_pkg::FIFO_DEPTH),
    .AW(bm_read_pkg::FIFO_AW)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_in_valid(beat),
    .i_in_data(i_mst_data),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(o_stream_valid),
    .o_out_data(o_stream_data),
    .i_out_ready(i_stream_ready),
    .o_level(fifo_level)
  );

  // Read channel registers, engine and register writes
  always_comb begin
    // One side owns the channel registers at a time
    bm_wr = i_addon_owns_bm ? (i_addon_sel && i_addon_wr) : (i_pci_sel && i_pci_wr); // [R11]
    bm_addr = i_addon_owns_bm ? i_addon_addr : i_pci_addr; // [R11]
    bm_be = i_addon_owns_bm ? i_addon_be : i_pci_be;
    bm_wdata = i_addon_owns_bm ? i_addon_wdata : i_pci_wdata;
    addr_word = {addr_reg, bm_read_pkg::ADDR_LOW_ZERO}; // [R1]
    addr_merged = merge(addr_word, bm_wdata, bm_be);

    // Write strobes for the two channel registers
    wr_addr_hit = bm_wr && (bm_addr == bm_read_pkg::OFS_BM_READ_ADDRESS);
    wr_count_hit = bm_wr && (bm_addr == bm_read_pkg::OFS_BM_READ_BYTE_COUNT);

    full_word = {in_full_reg, out_full_reg}; // [R12]
    beat = req_reg && i_mst_ack && fifo_in_ready;
    state_next = state_reg;
    addr_next = addr_reg;
    count_next = count_reg;
    done_next = done_reg;
    case (state_reg)
      bm_read_pkg::ST_IDLE: begin
        // Channel registers take writes only while no transfer runs
        if (wr_addr_hit) begin
          addr_next = addr_merged[31:bm_read_pkg::ADDR_LSB]; // [R1]
        end
        if (wr_count_hit) begin
          count_next = merge(count_reg, bm_wdata, bm_be);
        end
        // A zero count never starts a transfer
        if (i_read_enable && count_reg != bm_read_pkg::ZERO_WORD) begin // [R2]
          state_next = bm_read_pkg::ST_BURST;
        end
      end
      bm_read_pkg::ST_BURST: begin
        if (beat) begin
          if (count_reg >= bm_read_pkg::DWORD_BYTES) begin
            addr_next = addr_reg + 30'h1; // [R3] [R19]
            count_next = count_reg - bm_read_pkg::DWORD_BYTES; // [R8] [R19]
          end else begin
            count_next = bm_read_pkg::ZERO_WORD; // [R10] [R19]
          end
          if (count_next == bm_read_pkg::ZERO_WORD) begin
            state_next = bm_read_pkg::ST_DONE; // [R9]
          end
        end else if (!i_read_enable) begin
          state_next = bm_read_pkg::ST_IDLE;
        end
      end
      bm_read_pkg::ST_DONE: begin
        done_next = done_reg | i_done_irq_en; // [R9] [R20]
        state_next = bm_read_pkg::ST_IDLE;
      end
      default: begin
        state_next = bm_read_pkg::ST_IDLE;
      end
    endcase
    // Completion flag clear loses to a new completion
    if (i_done_clr && !(state_reg == bm_read_pkg::ST_DONE && i_done_irq_en)) begin
      done_next = 1'b0;
    end
    // Request only with room for the beat already in flight
    req_next = (state_next == bm_read_pkg::ST_BURST) && (count_next != bm_read_pkg::ZERO_WORD) &&
               (fifo_level < bm_read_pkg::FIFO_ROOM_LIMIT);
    addr_phase_next = req_next && !req_reg; // [R5] [R6]
    be_next = lane_mask(count_next); // [R10]
    busy_next = (state_next != bm_read_pkg::ST_IDLE);
  end

  // Register read data for both ports
  always_comb begin
    // Channel register read data for the owning side
    case (bm_addr)
      bm_read_pkg::OFS_BM_READ_ADDRESS: bm_rd_word = addr_word; // [R4]
      bm_read_pkg::OFS_BM_READ_BYTE_COUNT: bm_rd_word = count_reg;
      default: bm_rd_word = bm_read_pkg::ZERO_WORD;
    endcase

    // Target reads on the PCI side, unmapped offsets read zero
    pci_rvalid_next = i_pci_sel && !i_pci_wr;
    pci_rdata_next = bm_read_pkg::ZERO_WORD;
    if (i_pci_sel && !i_pci_wr) begin
      if (i_pci_addr == bm_read_pkg::OFS_MAILBOX_BYTE_FULLNESS) begin
        pci_rdata_next = full_word; // [R12]
      end else if (!i_addon_owns_bm) begin
        pci_rdata_next = bm_rd_word; // [R4]
      end
    end

    // Add-on reads see only the channel registers, and only as owner
    addon_rvalid_next = i_addon_sel && !i_addon_wr;
    addon_rdata_next = bm_read_pkg::ZERO_WORD;
    if (i_addon_sel && !i_addon_wr && i_addon_owns_bm) begin
      addon_rdata_next = bm_rd_word; // [R11]
    end
  end

  // Mailbox fullness, one flop pair per mailbox byte: a set in the same cycle as a clear wins
  for (genvar b = 0; b < $bits(in_full_reg); b++) begin : g_mb_byte
    logic in_bit_reg, in_bit_next, out_bit_reg, out_bit_next;

    always_comb begin
      in_bit_next = (in_bit_reg && !i_in_mb_rd_be[b]) || i_in_mb_wr_be[b]; // [R13] [R14] [R15] [R18]
      out_bit_next = (out_bit_reg && !i_out_mb_rd_be[b]) || i_out_mb_wr_be[b]; // [R13] [R14] [R16] [R17]
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        in_bit_reg <= bm_read_pkg::RST_MAILBOX_FULL[b];
        out_bit_reg <= bm_read_pkg::RST_MAILBOX_FULL[b];
      end else begin
        in_bit_reg <= in_bit_next;
        out_bit_reg <= out_bit_next;
      end
    end

    // Gathered into the status word
    assign in_full_reg[b] = in_bit_reg;
    assign out_full_reg[b] = out_bit_reg;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= bm_read_pkg::ST_IDLE;
      addr_reg <= bm_read_pkg::RST_BM_READ_ADDRESS[31:bm_read_pkg::ADDR_LSB];
      count_reg <= bm_read_pkg::RST_BM_READ_BYTE_COUNT;
      done_reg <= 1'b0;
      req_reg <= 1'b0;
      addr_phase_reg <= 1'b0;
      be_reg <= bm_read_pkg::BE_NONE;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      count_reg <= count_next;
      done_reg <= done_next;
      req_reg <= req_next;
      addr_phase_reg <= addr_phase_next;
      be_reg <= be_next;
      busy_reg <= busy_next;
    end
  end

  // Register read data flops
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pci_rdata_reg <= bm_read_pkg::ZERO_WORD;
      pci_rvalid_reg <= 1'b0;
      addon_rdata_reg <= bm_read_pkg::ZERO_WORD;
      addon_rvalid_reg <= 1'b0;
    end else begin
      pci_rdata_reg <= pci_rdata_next;
      pci_rvalid_reg <= pci_rvalid_next;
      addon_rdata_reg <= addon_rdata_next;
      addon_rvalid_reg <= addon_rvalid_next;
    end
  end

  assign o_pci_rdata = pci_rdata_reg;
  assign o_pci_rvalid = pci_rvalid_reg;
  assign o_addon_rdata = addon_rdata_reg;
  assign o_addon_rvalid = addon_rvalid_reg;
  assign o_read_busy = busy_reg;
  assign o_read_done = done_reg;
  assign o_mst_req = req_reg;
  assign o_mst_addr_phase = addr_phase_reg;
  // Low two address bits are constant zeros: linear burst order
  assign o_mst_addr = {addr_reg, bm_read_pkg::ADDR_LOW_ZERO}; // [R5] [R6]
  assign o_mst_be = be_reg;
endmodule

// *** verilog/bm_read_pkg.sv ***
// Constants, offsets and types for the bus-master read and mailbox status block
package bm_read_pkg;
  // Register offsets on the target register port
  localparam logic [7:0] OFS_BM_READ_ADDRESS = 8'h2c;
  localparam logic [7:0] OFS_BM_READ_BYTE_COUNT = 8'h30;
  localparam logic [7:0] OFS_MAILBOX_BYTE_FULLNESS = 8'h34;
  // Reset values
  localparam logic [31:0] RST_BM_READ_ADDRESS = 32'h0000_0000;
  localparam logic [31:0] RST_BM_READ_BYTE_COUNT = 32'h0000_0000;
  localparam logic [15:0] RST_MAILBOX_FULL = 16'h0000;
  // Address and count layout
  localparam int ADDR_LSB = 2;
  localparam logic [31:0] DWORD_BYTES = 32'h0000_0004;
  localparam logic [1:0] ADDR_LOW_ZERO = 2'h0;
  localparam logic [3:0] BE_ALL = 4'hf;
  localparam logic [3:0] BE_NONE = 4'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // Data FIFO shape and the room kept for a beat still in flight
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam logic [FIFO_AW:0] FIFO_ROOM_LIMIT = 5'h0d;
  // Read channel states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BURST = 2'b01,
    ST_DONE = 2'b10
  } rd_state_t;
endpackage

// *** verilog/data_fifo.sv ***
// Parameterised FIFO with a registered output stage
module data_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  // Fill level of the storage array
  output logic [AW:0] o_level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] level_reg, level_next;
  logic out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic push, pop;

  always_comb begin
    push = i_in_valid && (level_reg != (AW+1)'(DEPTH));
    pop = (level_reg != '0) && (!out_valid_reg || i_out_ready);
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    level_next = level_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    out_valid_next = pop ? 1'b1 : (i_out_ready ? 1'b0 : out_valid_reg);
    out_data_next = pop ? mem[rd_ptr_reg] : out_data_reg;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      level_reg <= level_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
    end
  end

  // Storage array carries no reset
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  assign o_in_ready = (level_reg != (AW+1)'(DEPTH));
  assign o_out_valid = out_valid_reg;
  assign o_out_data = out_data_reg;
  assign o_level = level_reg;
endmodule
